/* fwsb_defs.svh */
`ifndef FWSB_DEFS_SVH
`define FWSB_DEFS_SVH

// Register offsets
`define FWSB_ADDR_INPUT_STATUS   8'h7c
`define FWSB_ADDR_TEMP_STATUS    8'h7d
`define FWSB_ADDR_VENDOR_STATUS  8'h80

// Reset values
`define FWSB_RST_STATUS          8'h00
`define FWSB_RST_CAUSE           3'h0

// Input status field positions
`define FWSB_IN_OV_FAULT_BIT     7
`define FWSB_IN_OV_WARN_BIT      6
`define FWSB_IN_UV_WARN_BIT      5
`define FWSB_IN_UV_FAULT_BIT     4
`define FWSB_IN_OP_WARN_BIT      0

// Temperature status field positions
`define FWSB_TMP_OVERTEMPERATURE_FAULT_BIT    7
`define FWSB_TMP_OT_WARN_BIT     6

// Vendor status field positions
`define FWSB_VS_FET_HEALTH_BIT   7
`define FWSB_VS_UV_LIVE_BIT      6
`define FWSB_VS_OV_LIVE_BIT      5
`define FWSB_VS_SEVERE_OC_BIT    4
`define FWSB_VS_IN_LIMIT_BIT     3
`define FWSB_VS_CAUSE_MSB        2
`define FWSB_VS_CAUSE_LSB        0

// Shutdown cause codes
`define FWSB_CAUSE_NONE          3'h0
`define FWSB_CAUSE_OVERTEMP      3'h1
`define FWSB_CAUSE_TIMED_OC      3'h2
`define FWSB_CAUSE_FET_HEALTH    3'h3
`define FWSB_CAUSE_UNDERVOLT     3'h4
`define FWSB_CAUSE_OVERVOLT      3'h6

// Index of each latched flag in the sticky bank
`define FWSB_FLG_INPUT_OVERVOLTAGE_FAULT    0
`define FWSB_FLG_INPUT_OVERVOLTAGE_WARNING     1
`define FWSB_FLG_INPUT_UNDERVOLTAGE_WARNING     2
`define FWSB_FLG_INPUT_UNDERVOLTAGE_FAULT    3
`define FWSB_FLG_INPUT_OVERPOWER_WARNING     4
`define FWSB_FLG_OVERTEMPERATURE_FAULT        5
`define FWSB_FLG_OT_WARN         6
`define FWSB_FLG_FET_HEALTH      7
`define FWSB_FLG_SEVERE_OC       8
`define FWSB_FLG_IN_LIMIT        9
`define FWSB_FLG_COUNT           10

`endif

/* fwsb_pkg.sv */
`include "fwsb_defs.svh"

package fwsb_pkg;

    // Events reported by the power monitor and hot swap circuitry
    typedef struct packed {
        logic input_overvoltage_warning;
        logic input_undervoltage_warning;
        logic input_overpower_warning;
        logic overtemperature_fault;
        logic overtemperature_warning;
        logic pass_transistor_health_fault;
        logic severe_overcurrent_fault;
        logic current_limiting_active_flag;
    } fwsb_mon_evt_t;

    // Shutdown requests from the hot swap controller, one per cause
    typedef struct packed {
        logic overtemp;
        logic timed_overcurrent_fault;
        logic transistor_health;
        logic undervolt;
        logic overvolt;
    } fwsb_shdn_req_t;

    // Contents of the three status registers
    typedef struct packed {
        logic [7:0] input_supply_status;
        logic [7:0] temperature_status;
        logic [7:0] vendor_specific_status;
    } fwsb_status_t;

    // Read answer toward the host
    typedef struct packed {
        logic [7:0] data;
        logic       ack;
        logic       unmapped;
    } fwsb_rd_rsp_t;

    // Which register an address selects
    typedef struct packed {
        logic input_sel;
        logic temp_sel;
        logic vendor_sel;
    } fwsb_addr_hit_t;

    // State of the sticky bank
    typedef struct packed {
        logic [`FWSB_FLG_COUNT-1:0] flags;
    } fwsb_bank_state_t;

    // State of the cause recorder
    typedef struct packed {
        logic [2:0] cause;
    } fwsb_cause_state_t;

    // State of the top level
    typedef struct packed {
        fwsb_rd_rsp_t rsp;
        fwsb_status_t view;
    } fwsb_top_state_t;

endpackage

/* fwsb_sticky_bank.sv */
`include "fwsb_defs.svh"

module fwsb_sticky_bank
    import fwsb_pkg::*;
#(
    parameter int WIDTH = `FWSB_FLG_COUNT
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             reset_n,
    // Set and clear
    input  wire logic [WIDTH-1:0] set_vec,
    input  wire logic             clear_all,
    // Latched flags
    output logic      [WIDTH-1:0] flags_ff
);

    ////////////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] state_ff;
    logic [WIDTH-1:0] nxt_state;

    // Set wins over clear; flags hold otherwise
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_flag
            always_comb begin
                nxt_state[gi] = set_vec[gi] | (state_ff[gi] & ~clear_all);
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flags_ff = state_ff;

endmodule // fwsb_sticky_bank

/* fwsb_cause_recorder.sv */
`include "fwsb_defs.svh"

module fwsb_cause_recorder
    import fwsb_pkg::*;
(
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    // Shutdown requests and clear
    input  fwsb_shdn_req_t      shdn_req,
    input  wire logic           clear_all,
    // Recorded cause
    output logic [2:0]          cause_ff
);

    ////////////////////////////////////////////////////////////////////////////
    fwsb_cause_state_t state_ff;
    fwsb_cause_state_t nxt_state;

    // Fixed priority: overvoltage, undervoltage, transistor, overcurrent, temperature
    function automatic logic [2:0] encode_cause(input fwsb_shdn_req_t req);
        logic [2:0] code;
        code = `FWSB_CAUSE_NONE;
        if (req.overvolt) begin
            code = `FWSB_CAUSE_OVERVOLT;
        end else if (req.undervolt) begin
            code = `FWSB_CAUSE_UNDERVOLT;
        end else if (req.transistor_health) begin
            code = `FWSB_CAUSE_FET_HEALTH;
        end else if (req.timed_overcurrent_fault) begin
            code = `FWSB_CAUSE_TIMED_OC;
        end else if (req.overtemp) begin
            code = `FWSB_CAUSE_OVERTEMP;
        end
        return code;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        if (|shdn_req) begin
            nxt_state.cause = encode_cause(shdn_req);
        end else if (clear_all) begin
            nxt_state.cause = `FWSB_CAUSE_NONE;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff.cause <= `FWSB_RST_CAUSE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cause_ff = state_ff.cause;

endmodule // fwsb_cause_recorder

/* fwsb_status_bank.sv */
`include "fwsb_defs.svh"

// Notes on behaviour
// - Input bit 7 latches on overvoltage pin.
// - Input bit 6 latches on overvoltage warning.
// - Input bit 5 latches on undervoltage warning.
// - Input bit 4 latches on undervoltage pin.
// - Input bits 3 to 1 read zero.
// - Input bit 0 latches on overpower warning.
// - Temperature bit 7 latches on overtemperature fault.
// - Temperature bit 6 latches on overtemperature warning.
// - Temperature bits 5 to 0 read zero.
// - Vendor bit 7 latches on transistor health.
// - Vendor bit 6 follows undervoltage pin live.
// - Vendor bit 5 follows overvoltage pin live.
// - Vendor bit 4 latches on severe overcurrent.
// - Vendor bit 3 latches while limiting is active.
// - Cause field keeps last shutdown until cleared.
// - Cause reads zero after reset, or after a clear with no shutdown request.
// - Cause codes 001,010,011,100,110 per source.
module fwsb_status_bank
    import fwsb_pkg::*;
(
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    // Pin comparators, high while beyond threshold
    input  wire logic           overvoltage_sense_pin,
    input  wire logic           undervoltage_sense_pin,
    // Monitor and hot swap events
    input  fwsb_mon_evt_t       mon_evt,
    // Shutdown requests
    input  fwsb_shdn_req_t      shdn_req,
    // Host status clear
    input  wire logic           clear_faults,
    // Host read port
    input  wire logic           rd_req,
    input  wire logic [7:0]     rd_addr,
    output logic      [7:0]     rd_data_ff,
    output logic                rd_ack_ff,
    output logic                rd_unmapped_ff,
    // Registered register view and summary
    output fwsb_status_t        status_view_ff,
    output logic                input_active_ff,
    output logic                temp_active_ff,
    output logic                vendor_active_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by data select and unmapped flag
    function automatic fwsb_addr_hit_t decode_addr(input logic [7:0] addr);
        fwsb_addr_hit_t hit;
        hit.input_sel  = (addr == `FWSB_ADDR_INPUT_STATUS);
        hit.temp_sel   = (addr == `FWSB_ADDR_TEMP_STATUS);
        hit.vendor_sel = (addr == `FWSB_ADDR_VENDOR_STATUS);
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Latched flags
    logic [`FWSB_FLG_COUNT-1:0] flag_set;
    logic [`FWSB_FLG_COUNT-1:0] flags;
    logic [2:0]                 cause;

    always_comb begin
        flag_set = '0;
        flag_set[`FWSB_FLG_INPUT_OVERVOLTAGE_FAULT] = overvoltage_sense_pin;
        flag_set[`FWSB_FLG_INPUT_OVERVOLTAGE_WARNING]  = mon_evt.input_overvoltage_warning;
        flag_set[`FWSB_FLG_INPUT_UNDERVOLTAGE_WARNING]  = mon_evt.input_undervoltage_warning;
        flag_set[`FWSB_FLG_INPUT_UNDERVOLTAGE_FAULT] = undervoltage_sense_pin;
        flag_set[`FWSB_FLG_INPUT_OVERPOWER_WARNING]  = mon_evt.input_overpower_warning;
        flag_set[`FWSB_FLG_OVERTEMPERATURE_FAULT]     = mon_evt.overtemperature_fault;
        flag_set[`FWSB_FLG_OT_WARN]      = mon_evt.overtemperature_warning;
        flag_set[`FWSB_FLG_FET_HEALTH]   = mon_evt.pass_transistor_health_fault;
        flag_set[`FWSB_FLG_SEVERE_OC]    = mon_evt.severe_overcurrent_fault;
        flag_set[`FWSB_FLG_IN_LIMIT]     = mon_evt.current_limiting_active_flag;
    end

    fwsb_sticky_bank #(
        .WIDTH     (`FWSB_FLG_COUNT)
    ) u_flags (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .set_vec   (flag_set),
        .clear_all (clear_faults),
        .flags_ff  (flags)
    );

    fwsb_cause_recorder u_cause (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .shdn_req  (shdn_req),
        .clear_all (clear_faults),
        .cause_ff  (cause)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register contents
    fwsb_status_t cur;

    always_comb begin
        cur = '0;
        cur.input_supply_status[`FWSB_IN_OV_FAULT_BIT] = flags[`FWSB_FLG_INPUT_OVERVOLTAGE_FAULT];
        cur.input_supply_status[`FWSB_IN_OV_WARN_BIT]  = flags[`FWSB_FLG_INPUT_OVERVOLTAGE_WARNING];
        cur.input_supply_status[`FWSB_IN_UV_WARN_BIT]  = flags[`FWSB_FLG_INPUT_UNDERVOLTAGE_WARNING];
        cur.input_supply_status[`FWSB_IN_UV_FAULT_BIT] = flags[`FWSB_FLG_INPUT_UNDERVOLTAGE_FAULT];
        cur.input_supply_status[`FWSB_IN_OP_WARN_BIT]  = flags[`FWSB_FLG_INPUT_OVERPOWER_WARNING];
        cur.temperature_status[`FWSB_TMP_OVERTEMPERATURE_FAULT_BIT] = flags[`FWSB_FLG_OVERTEMPERATURE_FAULT];
        cur.temperature_status[`FWSB_TMP_OT_WARN_BIT]  = flags[`FWSB_FLG_OT_WARN];
        cur.vendor_specific_status[`FWSB_VS_FET_HEALTH_BIT] = flags[`FWSB_FLG_FET_HEALTH];
        cur.vendor_specific_status[`FWSB_VS_UV_LIVE_BIT] = undervoltage_sense_pin;
        cur.vendor_specific_status[`FWSB_VS_OV_LIVE_BIT] = overvoltage_sense_pin;
        cur.vendor_specific_status[`FWSB_VS_SEVERE_OC_BIT] = flags[`FWSB_FLG_SEVERE_OC];
        cur.vendor_specific_status[`FWSB_VS_IN_LIMIT_BIT]  = flags[`FWSB_FLG_IN_LIMIT];
        cur.vendor_specific_status[`FWSB_VS_CAUSE_MSB:`FWSB_VS_CAUSE_LSB] = cause;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read answer and registered view
    fwsb_top_state_t state_ff;
    fwsb_top_state_t nxt_state;
    fwsb_addr_hit_t  hit;

    always_comb begin
        hit                = decode_addr(rd_addr);
        nxt_state          = state_ff;
        nxt_state.view     = cur;
        nxt_state.rsp.ack  = rd_req;
        if (rd_req) begin
            nxt_state.rsp.unmapped = ~(|hit);
            nxt_state.rsp.data     = `FWSB_RST_STATUS;
            if (hit.input_sel) begin
                nxt_state.rsp.data = cur.input_supply_status;
            end else if (hit.temp_sel) begin
                nxt_state.rsp.data = cur.temperature_status;
            end else if (hit.vendor_sel) begin
                nxt_state.rsp.data = cur.vendor_specific_status;
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff.rsp.data                  <= `FWSB_RST_STATUS;
            state_ff.rsp.ack                   <= 1'b0;
            state_ff.rsp.unmapped              <= 1'b0;
            state_ff.view.input_supply_status    <= `FWSB_RST_STATUS;
            state_ff.view.temperature_status     <= `FWSB_RST_STATUS;
            state_ff.view.vendor_specific_status <= `FWSB_RST_STATUS;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rd_data_ff       = state_ff.rsp.data;
    assign rd_ack_ff        = state_ff.rsp.ack;
    assign rd_unmapped_ff   = state_ff.rsp.unmapped;
    assign status_view_ff   = state_ff.view;
    assign input_active_ff  = |state_ff.view.input_supply_status;
    assign temp_active_ff   = |state_ff.view.temperature_status;
    assign vendor_active_ff = |state_ff.view.vendor_specific_status;

endmodule // fwsb_status_bank

/* fwsb_host_model.sv */
module fwsb_host_model (
    // Clock
    input  wire logic       core_clk,
    // Read request
    output logic            rd_req,
    output logic [7:0]      rd_addr,
    // Read answer
    input  wire logic [7:0] rd_data_ff,
    input  wire logic       rd_ack_ff,
    input  wire logic       rd_unmapped_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rd_req = 1'b0;
        rd_addr = 8'h5a;
    end

    // One read, answer taken one cycle later
    task read(input logic [7:0] a, output logic [7:0] d, output logic k, output logic u);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge core_clk);
        d = rd_data_ff;
        k = rd_ack_ff;
        u = rd_unmapped_ff;
    endtask

    // Release, address no longer meaningful
    task idle;
        rd_req = 1'b0;
        rd_addr = ~rd_addr;
    endtask
endmodule // fwsb_host_model

/* fwsb_status_bank_sva.sv */
module fwsb_status_bank_sva
    import fwsb_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       reset_n,
    // Inputs
    input wire logic       overvoltage_sense_pin,
    input wire logic       undervoltage_sense_pin,
    input fwsb_mon_evt_t   mon_evt,
    input fwsb_shdn_req_t  shdn_req,
    input wire logic       clear_faults,
    input wire logic       rd_req,
    input wire logic [7:0] rd_addr,
    // Outputs
    input wire logic [7:0] rd_data_ff,
    input wire logic       rd_ack_ff,
    input fwsb_status_t    status_view_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    a_read_ack: assert property (rd_ack_ff == $past(rd_req))
        else $error("read not answered");
    a_ov_latch: assert property (overvoltage_sense_pin |-> ##2 status_view_ff[23])
        else $error("overvoltage fault not latched");
    a_uvw_latch: assert property (mon_evt.input_undervoltage_warning |-> ##2 status_view_ff[21])
        else $error("undervoltage warning not latched");
    a_resv_zero: assert property (status_view_ff[19:17] == 3'h0 && status_view_ff[13:8] == 6'h00)
        else $error("reserved bits set");
    a_ot_latch: assert property (mon_evt.overtemperature_fault |-> ##2 status_view_ff[15])
        else $error("overtemperature fault not latched");
    a_uv_live: assert property (rd_req && rd_addr == 8'h80 |=> rd_data_ff[6] == $past(undervoltage_sense_pin))
        else $error("undervoltage live bit wrong");
    a_ov_live: assert property (rd_req && rd_addr == 8'h80 |=> rd_data_ff[5] == $past(overvoltage_sense_pin))
        else $error("overvoltage live bit wrong");
    a_limit_latch: assert property (mon_evt.current_limiting_active_flag |-> ##2 status_view_ff[3])
        else $error("limiting flag not latched");
    a_cause_ov: assert property (shdn_req.overvolt |-> ##2 status_view_ff[2:0] == 3'h6)
        else $error("overvoltage cause wrong");
    a_flag_hold: assert property (status_view_ff[15] && !$past(clear_faults) |=> status_view_ff[15])
        else $error("latched flag lost");
    a_cause_legal: assert property (status_view_ff[2:0] != 3'h5 && status_view_ff[2:0] != 3'h7)
        else $error("unused cause code");

    c_vendor_read: cover property (rd_req && rd_addr == 8'h80);
    c_shutdown: cover property (shdn_req.overvolt);
    c_clear_set: cover property (clear_faults && status_view_ff != 24'h0);
endmodule // fwsb_status_bank_sva

bind fwsb_status_bank fwsb_status_bank_sva u_sva (.core_clk, .reset_n, .overvoltage_sense_pin,
    .undervoltage_sense_pin, .mon_evt, .shdn_req, .clear_faults, .rd_req, .rd_addr, .rd_data_ff,
    .rd_ack_ff, .status_view_ff);

/* tb_fwsb_status_bank.sv */
module tb_fwsb_status_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import fwsb_pkg::*;

    logic           core_clk, reset_n, overvoltage_sense_pin, undervoltage_sense_pin;
    fwsb_mon_evt_t  mon_evt;
    fwsb_shdn_req_t shdn_req;
    logic           clear_faults, rd_req, rd_ack_ff, rd_unmapped_ff;
    logic [7:0]     rd_addr, rd_data_ff, e_in, e_tmp, e_vs, a;
    logic [2:0]     e_cause;
    fwsb_status_t   status_view_ff;
    logic           input_active_ff, temp_active_ff, vendor_active_ff;
    int             err_total, check_count, i;
    logic [7:0]     addr_list [5] = '{8'h7c, 8'h7d, 8'h80, 8'h7e, 8'hff};

    fwsb_status_bank DUT (.core_clk, .reset_n, .overvoltage_sense_pin, .undervoltage_sense_pin,
        .mon_evt, .shdn_req, .clear_faults, .rd_req, .rd_addr, .rd_data_ff, .rd_ack_ff,
        .rd_unmapped_ff, .status_view_ff, .input_active_ff, .temp_active_ff, .vendor_active_ff);
    fwsb_host_model HOST (.core_clk, .rd_req, .rd_addr, .rd_data_ff, .rd_ack_ff, .rd_unmapped_ff);

    always #10 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    task chk8(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task chk1(input logic g, input logic e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic logic [2:0] code(input fwsb_shdn_req_t s);
        if (s.overvolt) return 3'h6;
        if (s.undervolt) return 3'h4;
        if (s.transistor_health) return 3'h3;
        if (s.timed_overcurrent_fault) return 3'h2;
        if (s.overtemp) return 3'h1;
        return 3'h0;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic ov, input logic uv);
        case (ad)
            8'h7c: return e_in;
            8'h7d: return e_tmp;
            8'h80: return {e_vs[7], uv, ov, e_vs[4:3], e_cause};
            default: return 8'h00;
        endcase
    endfunction

    // One cycle of events with a read of address ad in the same cycle
    task step(input fwsb_mon_evt_t ev, input fwsb_shdn_req_t sd, input logic ov, input logic uv,
              input logic clr, input logic [7:0] ad);
        logic [7:0] d, x;
        logic       k, u;
        logic [23:0] v;
        mon_evt = ev;
        shdn_req = sd;
        overvoltage_sense_pin = ov;
        undervoltage_sense_pin = uv;
        clear_faults = clr;
        x = exp_rd(ad, ov, uv);
        v = {exp_rd(8'h7c, ov, uv), exp_rd(8'h7d, ov, uv), exp_rd(8'h80, ov, uv)};
        HOST.read(ad, d, k, u);
        if (clr) {e_in, e_tmp, e_vs, e_cause} = '0;
        e_in |= {ov, ev.input_overvoltage_warning, ev.input_undervoltage_warning, uv, 3'h0,
                 ev.input_overpower_warning};
        e_tmp |= {ev.overtemperature_fault, ev.overtemperature_warning, 6'h00};
        e_vs |= {ev.pass_transistor_health_fault, 2'h0, ev.severe_overcurrent_fault,
                 ev.current_limiting_active_flag, 3'h0};
        if (|sd) e_cause = code(sd);
        chk8(d, x);
        chk1(k, 1'b1);
        chk1(u, !(ad inside {8'h7c, 8'h7d, 8'h80}));
        chk8(status_view_ff[23:16], v[23:16]);
        chk8(status_view_ff[15:8], v[15:8]);
        chk8(status_view_ff[7:0], v[7:0]);
        chk1(input_active_ff, |v[23:16]);
        chk1(temp_active_ff, |v[15:8]);
        chk1(vendor_active_ff, |v[7:0]);
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100us;
        err_total++;
        stop_test;
    end

    initial begin
        {core_clk, reset_n, overvoltage_sense_pin, undervoltage_sense_pin, clear_faults} = '0;
        {mon_evt, shdn_req, e_in, e_tmp, e_vs, e_cause} = '0;
        err_total = 0;
        check_count = 0;
        i = $urandom(32'ha2cf1ecc);
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        foreach (addr_list[j])
            step('0, '0, 1'b0, 1'b0, 1'b0, addr_list[j]);
        $display("test reset values done");
        for (i = 0; i < 5; i++) begin
            step('0, 5'(1 << i), 1'b0, 1'b0, 1'b0, 8'h80);
            step('0, '0, 1'b0, 1'b0, 1'b0, 8'h80);
            step('0, '0, 1'b0, 1'b0, 1'b1, 8'h80);
        end
        $display("test cause codes done");
        repeat (400) begin
            a = ($urandom % 4 == 3) ? 8'($urandom) : 8'h7c + 8'($urandom % 3);
            if (a == 8'h7e) a = 8'h80;
            step(8'($urandom & $urandom & $urandom), 5'($urandom & $urandom & $urandom),
                 $urandom % 8 == 0, $urandom % 8 == 0, $urandom % 10 == 0, a);
        end
        $display("test random traffic done");
        HOST.idle;
        reset_n = 1'b0;
        @(negedge core_clk);
        reset_n = 1'b1;
        {e_in, e_tmp, e_vs, e_cause} = '0;
        for (i = 0; i < 3; i++)
            step('0, '0, 1'b0, 1'b0, 1'b0, 8'h7c + 8'(i) + 8'(i / 2 * 2));
        HOST.idle;
        $display("test second reset done");
        stop_test;
    end
endmodule // tb_fwsb_status_bank
